//--- sadc_cfg.svh
// sadc_cfg.svh: register offsets, field positions, reset values, timing
// assumes: included by the package and the design file by bare name
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
`define SADC_NCH 12
`define SADC_NCJ 6
`define SADC_RES_W 24
`define SADC_CJ_W 16
`define SADC_CLK_HZ 100000000
`define SADC_MAX_RATE 1800
`define SADC_CJ_POLL_MS 250
`define SADC_REG_CTRL 6'h00
`define SADC_REG_CHSEL 6'h01
`define SADC_REG_RATE 6'h02
`define SADC_REG_STAT 6'h03
`define SADC_REG_MASK 6'h04
`define SADC_REG_BIAS 6'h05
`define SADC_REG_BURN 6'h06
`define SADC_REG_DIO 6'h07
`define SADC_REG_RDPTR 6'h08
`define SADC_REG_DATA 6'h09
`define SADC_REG_CJ0 6'h0a
`define SADC_REG_GAIN0 6'h10
`define SADC_REG_GAIN1 6'h11
`define SADC_CTRL_RUN 0
`define SADC_CTRL_CFG 1
`define SADC_CTRL_STS 2
`define SADC_EV_SET 0
`define SADC_EV_OVR 1
`define SADC_EV_CJ 2
`define SADC_EV_BURN 3
`define SADC_EV_W 4
`define SADC_RATE_RST 32'h0000_d903
`define SADC_CHSEL_RST 12'hfff
`define SADC_BIAS_RST 12'hfff
`define SADC_CFG_BITS 4
`define SADC_GAIN0_BITS 30
`define SADC_SLOW_PER 32'd5000000
`endif

//--- sadc_pkg.sv
// sadc_pkg.sv: types shared by the acquisition controller
// assumes: sadc_cfg.svh is on the include path
`include "sadc_cfg.svh"
package sadc_pkg;
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_WAIT = 2'b01,
		SADC_STORE = 2'b10
	} sadc_state_t;
	typedef logic [2:0] sadc_gain_t;
endpackage

//--- sadc_ctrl.sv
// sadc_ctrl.sv: simultaneous acquisition controller for twelve converters
// assumes: converters answer a common start strobe with done plus data;
// sensor transactions are done by an external byte engine per line
// What this block does
// - one start strobe goes to all selected converters in the same cycle.
// - each sampled channel returns a 24-bit result kept in the output buffer.
// - results are stored and read out in ascending channel order.
// - the channel list is a bit mask so no channel can appear twice.
// - the sample timer allows up to 1800 sets per second per channel.
// - each channel has its own filter, all set alike from the sample rate register.
// - a common converter clock and sync plus per-channel config commands.
// - the gain of each channel is set to 1, 2, 4, 8, 16, 32 or 64.
// - the first result after a start is kept, none is discarded.
// - the thermocouple bias is on after reset unless software clears it.
// - burnout flags from the converters are reported per channel.
// - up to six sensor lines each give a 16-bit temperature.
// - the two panel sensors are polled once every 250 ms.
// - one digital output is driven and one digital input is sampled.
// - ready shows whenever out of reset and status follows a software bit.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "sadc_cfg.svh"
module sadc_ctrl #(
	parameter int NCH = `SADC_NCH,
	parameter int NCJ = `SADC_NCJ,
	parameter int POLL_CYC = (`SADC_CLK_HZ / 1000) * `SADC_CJ_POLL_MS,
	parameter int CLK_DIV = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	output logic conv_clk,
	output logic conv_sync,
	output logic [NCH-1:0] conv_start,
	output logic [NCH-1:0] conv_cfg_load,
	output logic [`SADC_CFG_BITS-1:0] conv_cfg_word,
	output logic [NCH-1:0] conv_bias_en,
	input wire logic [NCH-1:0] conv_done,
	input wire logic [NCH*`SADC_RES_W-1:0] conv_data,
	input wire logic [NCH-1:0] conv_burnout,
	output logic [1:0] cj_req,
	input wire logic [NCJ-1:0] cj_valid,
	input wire logic [NCJ*`SADC_CJ_W-1:0] cj_data,
	output logic dout,
	input wire logic din,
	output logic led_ready,
	output logic user_status_indicator
);
	import sadc_pkg::*;

	localparam int RW = `SADC_RES_W;
	localparam int CW = `SADC_CJ_W;
	// shortest legal set period, at the top rate
	localparam int MIN_PER = `SADC_CLK_HZ / `SADC_MAX_RATE;
	localparam int GLO = `SADC_GAIN0_BITS;
	localparam int GHI = NCH * 3;

	sadc_state_t state;
	logic [2:0] ctrl;
	logic [NCH-1:0] chsel;
	logic [31:0] rate;
	logic [`SADC_EV_W-1:0] stat;
	logic [`SADC_EV_W-1:0] mask;
	logic [NCH-1:0] bias;
	logic [NCH-1:0] burn;
	logic [NCH*3-1:0] gain;
	logic [RW-1:0] buf_mem [NCH];
	logic [NCH-1:0] pend;
	logic [3:0] rdptr;
	logic unread;
	logic [31:0] tmr;
	logic [31:0] poll;
	logic [7:0] div;
	logic [CW-1:0] cj_mem [NCJ];
	logic [`SADC_EV_W-1:0] ev;
	logic [3:0] cfg_idx;
	logic cfg_busy;
	logic acc;
	logic wr;
	logic rd_data;
	logic tick;
	logic [31:0] per;
	logic [31:0] rd_val;
	logic set_done;
	logic burn_new;

	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = acc && wb_we_i && (wb_sel_i == 4'hf);
	assign rd_data = acc && !wb_we_i && (wb_adr_i[7:2] == `SADC_REG_DATA);
	assign per = (rate < MIN_PER) ? MIN_PER : rate;
	assign tick = ctrl[`SADC_CTRL_RUN] && (tmr >= per - 32'd1);
	assign set_done = (state == SADC_WAIT) && ((pend & ~conv_done) == '0);
	assign burn_new = |(conv_burnout & chsel & ~burn);
	// wishbone ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= acc;
		end
	end
	// control registers written by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
			chsel <= `SADC_CHSEL_RST;
			rate <= `SADC_RATE_RST;
			mask <= '0;
			bias <= `SADC_BIAS_RST;
			gain <= '0;
			dout <= 1'b0;
		end else if (wr) begin
			if (wb_adr_i[7:2] == `SADC_REG_CTRL) begin
				ctrl <= wb_dat_i[2:0];
			end else if (wb_adr_i[7:2] == `SADC_REG_CHSEL) begin
				chsel <= wb_dat_i[NCH-1:0];
			end else if (wb_adr_i[7:2] == `SADC_REG_RATE) begin
				rate <= wb_dat_i;
			end else if (wb_adr_i[7:2] == `SADC_REG_MASK) begin
				mask <= wb_dat_i[`SADC_EV_W-1:0];
			end else if (wb_adr_i[7:2] == `SADC_REG_BIAS) begin
				bias <= wb_dat_i[NCH-1:0];
			end else if (wb_adr_i[7:2] == `SADC_REG_DIO) begin
				dout <= wb_dat_i[0];
			end else if (wb_adr_i[7:2] == `SADC_REG_GAIN0) begin
				// three-bit gain code per channel, 1 to 64
				gain[GLO-1:0] <= wb_dat_i[GLO-1:0];
			end else if (wb_adr_i[7:2] == `SADC_REG_GAIN1) begin
				gain[GHI-1:GLO] <= wb_dat_i[GHI-GLO-1:0];
			end
		end
	end
	// sample timebase, period clamped to the top rate
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr <= '0;
		end else if (!ctrl[`SADC_CTRL_RUN] || tick) begin
			tmr <= '0;
		end else begin
			tmr <= tmr + 32'd1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= '0;
			conv_clk <= 1'b0;
			conv_sync <= 1'b0;
		end else begin
			conv_sync <= tick;
			if (div == 8'(CLK_DIV - 1)) begin
				div <= '0;
				conv_clk <= !conv_clk;
			end else begin
				div <= div + 8'd1;
			end
		end
	end
	// per-channel config walk: gain and filter code to each converter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_busy <= 1'b0;
			cfg_idx <= '0;
			conv_cfg_load <= '0;
			conv_cfg_word <= '0;
		end else begin
			conv_cfg_load <= '0;
			if (!cfg_busy) begin
				cfg_idx <= '0;
				cfg_busy <= wr && (wb_adr_i[7:2] == `SADC_REG_CTRL)
					&& wb_dat_i[`SADC_CTRL_CFG];
			end else begin
				conv_cfg_load[cfg_idx] <= 1'b1;
				// per-channel filter follows the rate; gain code
				conv_cfg_word <= {rate > `SADC_SLOW_PER, gain[cfg_idx*3 +: 3]};
				if (cfg_idx == 4'(NCH - 1)) begin
					cfg_busy <= 1'b0;
				end else begin
					cfg_idx <= cfg_idx + 4'd1;
				end
			end
		end
	end
	assign conv_bias_en = bias;
	// acquisition sequence
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SADC_IDLE;
			pend <= '0;
			conv_start <= '0;
		end else begin
			conv_start <= '0;
			case (state)
				SADC_IDLE: begin
					if (tick && chsel != '0) begin
						// one strobe to all selected converters
						conv_start <= chsel;
						pend <= chsel;
						state <= SADC_WAIT;
					end
				end
				SADC_WAIT: begin
					// first result kept; a channel leaves pend once seen
					pend <= pend & ~conv_done;
					if (set_done) begin
						state <= SADC_STORE;
					end
				end
				default: begin
					state <= SADC_IDLE;
				end
			endcase
		end
	end
	// buffer indexed by channel number, ascending order by address
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_buf
			always_ff @(posedge clk) begin
				if (state == SADC_WAIT && pend[i] && conv_done[i]) begin
					buf_mem[i] <= conv_data[i*RW +: RW];
				end
			end
		end
	endgenerate
	// read pointer walks all twelve channels in ascending order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdptr <= '0;
			unread <= 1'b0;
		end else if (state == SADC_STORE) begin
			rdptr <= '0;
			unread <= 1'b1;
		end else if (rd_data) begin
			if (rdptr == 4'(NCH - 1)) begin
				rdptr <= '0;
				unread <= 1'b0;
			end else begin
				rdptr <= rdptr + 4'd1;
			end
		end
	end
	// poll the two panel sensors every 250 ms
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			poll <= '0;
			cj_req <= '0;
		end else begin
			cj_req <= '0;
			if (poll == 32'(POLL_CYC - 1)) begin
				poll <= '0;
				cj_req <= 2'b11;
			end else begin
				poll <= poll + 32'd1;
			end
		end
	end
	generate
		for (genvar j = 0; j < NCJ; j++) begin : g_cj
			always_ff @(posedge clk) begin
				if (cj_valid[j]) begin
					cj_mem[j] <= cj_data[j*CW +: CW];
				end
			end
		end
	endgenerate
	// sticky burnout per channel, cleared by writing ones
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			burn <= '0;
		end else begin
			for (int k = 0; k < NCH; k++) begin
				if (conv_burnout[k] && chsel[k]) begin
					burn[k] <= 1'b1;
				end else if (wr && wb_adr_i[7:2] == `SADC_REG_BURN
					&& wb_dat_i[k]) begin
					burn[k] <= 1'b0;
				end
			end
		end
	end
	always_comb begin
		ev = '0;
		ev[`SADC_EV_SET] = (state == SADC_STORE);
		// overrun when a new set lands before the old one was read
		ev[`SADC_EV_OVR] = (state == SADC_STORE) && unread;
		ev[`SADC_EV_CJ] = |cj_valid;
		ev[`SADC_EV_BURN] = burn_new;
	end
	// sticky status, set wins over write-one clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat <= '0;
		end else if (wr && wb_adr_i[7:2] == `SADC_REG_STAT) begin
			stat <= (stat & ~wb_dat_i[`SADC_EV_W-1:0]) | ev;
		end else begin
			stat <= stat | ev;
		end
	end
	assign irq = |(stat & mask);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			led_ready <= 1'b0;
			user_status_indicator <= 1'b0;
		end else begin
			led_ready <= 1'b1;
			user_status_indicator <= ctrl[`SADC_CTRL_STS];
		end
	end
	always_comb begin
		rd_val = '0;
		if (wb_adr_i[7:2] == `SADC_REG_CTRL) begin
			rd_val[2:0] = ctrl;
		end else if (wb_adr_i[7:2] == `SADC_REG_CHSEL) begin
			rd_val[NCH-1:0] = chsel;
		end else if (wb_adr_i[7:2] == `SADC_REG_RATE) begin
			rd_val = rate;
		end else if (wb_adr_i[7:2] == `SADC_REG_STAT) begin
			rd_val[`SADC_EV_W-1:0] = stat;
		end else if (wb_adr_i[7:2] == `SADC_REG_MASK) begin
			rd_val[`SADC_EV_W-1:0] = mask;
		end else if (wb_adr_i[7:2] == `SADC_REG_BIAS) begin
			rd_val[NCH-1:0] = bias;
		end else if (wb_adr_i[7:2] == `SADC_REG_BURN) begin
			rd_val[NCH-1:0] = burn;
		end else if (wb_adr_i[7:2] == `SADC_REG_DIO) begin
			rd_val[1:0] = {din, dout};
		end else if (wb_adr_i[7:2] == `SADC_REG_RDPTR) begin
			rd_val[4:0] = {unread, rdptr};
		end else if (wb_adr_i[7:2] == `SADC_REG_DATA) begin
			rd_val[RW-1:0] = buf_mem[rdptr];
		end else if (wb_adr_i[7:2] >= `SADC_REG_CJ0
			&& wb_adr_i[7:2] < `SADC_REG_CJ0 + 6'(NCJ)) begin
			rd_val[CW-1:0] = cj_mem[3'(wb_adr_i[7:2] - `SADC_REG_CJ0)];
		end else if (wb_adr_i[7:2] == `SADC_REG_GAIN0) begin
			rd_val[GLO-1:0] = gain[GLO-1:0];
		end else if (wb_adr_i[7:2] == `SADC_REG_GAIN1) begin
			rd_val[GHI-GLO-1:0] = gain[GHI-1:GLO];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= '0;
		end else if (acc) begin
			wb_dat_o <= rd_val;
		end
	end
	// start reaches every selected converter together
	a_start_all: assert property (@(posedge clk) disable iff (!rst_n)
		(state == SADC_IDLE && tick && chsel != '0)
		|=> conv_start == $past(chsel)) else $error("start not common");
	// overrun flag follows a store with unread data
	a_overrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(state == SADC_STORE && unread) |=> stat[`SADC_EV_OVR])
		else $error("overrun not flagged");
	a_bias_reset: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> conv_bias_en == `SADC_BIAS_RST)
		else $error("bias not on by default");
	// no second set tick in the two cycles after one
	a_rate_limit: assert property (@(posedge clk) disable iff (!rst_n)
		tick |=> !tick [*2]) else $error("rate too high");
	sequence s_store;
		state == SADC_STORE;
	endsequence
	// buffer reading restarts at channel zero after a set
	a_order_reset: assert property (@(posedge clk) disable iff (!rst_n)
		s_store |=> rdptr == 4'd0 && unread) else $error("order start");
	a_status_led: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> user_status_indicator == $past(ctrl[`SADC_CTRL_STS]))
		else $error("status led stale");
	// burnout on a selected channel becomes sticky
	a_burn_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		burn_new |=> stat[`SADC_EV_BURN] && burn != '0)
		else $error("burnout lost");
	// sensor request pulse lasts one cycle
	a_poll_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		cj_req == 2'b11 |=> cj_req == 2'b00) else $error("poll pulse");
	// wishbone answers the cycle after a request
	a_bus_ack: assert property (@(posedge clk) disable iff (!rst_n)
		acc |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
endmodule

//--- sadc_conv_model.sv
// sadc_conv_model.sv: twelve converters and the two panel sensors
// assumes: start and sensor requests are one-cycle pulses on clk
`timescale 1ns/1ns
module sadc_conv_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] conv_start,
	input wire logic [1:0] cj_req,
	input wire logic [23:0] base,
	input wire logic [15:0] cj_val,
	output logic [11:0] conv_done,
	output logic [287:0] conv_data,
	output logic [5:0] cj_valid,
	output logic [95:0] cj_data
);
	int cnt [12];
	int cold_junction_sensor;
	// first result after a start is final
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_done <= '0;
			conv_data <= '1;
			for (int i = 0; i < 12; i++) cnt[i] <= 0;
		end else begin
			for (int i = 0; i < 12; i++) begin
				// channel i answers after 4+3*i cycles, holds 20
				if (conv_start[i]) cnt[i] <= 24 + 3 * i;
				else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
				if (cnt[i] == 21) begin
					conv_done[i] <= 1'b1;
					conv_data[i*24+:24] <= base ^ 24'(i * 24'h010203);
				end
				// released data no longer shows the result
				if (cnt[i] == 1) begin
					conv_done[i] <= 1'b0;
					conv_data[i*24+:24] <= ~conv_data[i*24+:24];
				end
			end
		end
	end
	// sensors answer a request with one 16-bit value each
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cold_junction_sensor <= 0;
			cj_valid <= '0;
			cj_data <= '1;
		end else begin
			cold_junction_sensor <= cj_req[0] ? 5 : (cold_junction_sensor > 0 ? cold_junction_sensor - 1 : 0);
			cj_valid <= {4'h0, {2{cold_junction_sensor == 1}}};
			if (cold_junction_sensor == 1) cj_data[31:0] <= {cj_val ^ 16'h00ff, cj_val};
			else cj_data <= ~cj_data;
		end
	end
endmodule

//--- tb_sadc_ctrl.sv
// tb_sadc_ctrl.sv: self-checking bench for the acquisition controller
// assumes: sadc_conv_model stands in for converters and sensors
`timescale 1ns/1ns
module tb_sadc_ctrl;
	import sadc_pkg::*;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, din = 0;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rs = 32'h3aa9, g = '0, em, mm, wb_dat_o;
	logic wb_ack_o, irq, conv_clk, conv_sync, dout, led_ready, usi;
	logic [11:0] conv_start, cfg_ld, bias, done, burn = '0, chs = '0;
	logic [3:0] cfg_w;
	logic [287:0] cdat;
	logic [1:0] cj_req;
	logic [5:0] cj_valid;
	logic [95:0] cj_data;
	logic [23:0] base = '0;
	logic [15:0] cjv = '0;
	logic [31:0] exp_q[$], msk_q[$];
	int fail_count = 0, compares = 0, ncj = 0, nld = 0, n;
	always #5 clk = ~clk;
	sadc_ctrl #(.POLL_CYC(50)) dut (.clk(clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .irq(irq), .conv_clk(conv_clk),
		.conv_sync(conv_sync), .conv_start(conv_start),
		.conv_cfg_load(cfg_ld), .conv_cfg_word(cfg_w),
		.conv_bias_en(bias), .conv_done(done), .conv_data(cdat),
		.conv_burnout(burn), .cj_req(cj_req), .cj_valid(cj_valid),
		.cj_data(cj_data), .dout(dout), .din(din),
		.led_ready(led_ready), .user_status_indicator(usi));
	sadc_conv_model far (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
		.cj_req(cj_req), .base(base), .cj_val(cjv), .conv_done(done),
		.conv_data(cdat), .cj_valid(cj_valid), .cj_data(cj_data));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task check(input logic [31:0] got, input logic [31:0] e);
		compares++;
		if (got !== e) begin
			fail_count++;
			$display("mismatch %0t got %h expected %h", $time, got, e);
		end
	endtask
	task end_of_test();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task xfer(input logic [5:0] wa, input logic w, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {wa, 2'b00};
		wdat <= d;
		sel <= 4'hf;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 100) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task wr(input logic [5:0] wa, input logic [31:0] d);
		xfer(wa, 1'b1, d);
	endtask
	task rd(input logic [5:0] wa, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		xfer(wa, 1'b0, '0);
	endtask
	task wait_cond(input int lim, input int which);
		n = 0;
		while (n < lim && !(which ? irq === 1'b1 : nld >= 12)) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) begin
			fail_count++;
			end_of_test();
		end
	endtask
	// monitor: read results against the oldest note, plus converter strobes
	always @(posedge clk) begin
		if (wb_ack_o && cyc && !we && exp_q.size() > 0) begin
			em = exp_q.pop_front();
			mm = msk_q.pop_front();
			check(wb_dat_o & mm, em & mm);
		end
		if (|conv_start) begin
			check({20'h0, conv_start}, {20'h0, chs});
			check({31'h0, conv_sync}, 32'h1);
		end
		if (|cfg_ld) begin
			nld++;
			for (int i = 0; i < 12; i++)
				if (cfg_ld[i])
					check({28'h0, cfg_w}, 32'(i < 10 ? i % 7 : 0));
		end
		if (cj_req == 2'b11) ncj++;
	end
	initial begin
		rs = xs(rs);
		base = rs[23:0];
		rs = xs(rs);
		cjv = rs[15:0];
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(6'h01, 32'hfff, 32'hfff);
		rd(6'h05, 32'hfff, 32'hfff);
		rd(6'h02, 32'h0000d903, '1);
		rd(6'h3f, 32'h0, '1);
		check({20'h0, bias}, 32'hfff);
		check({31'h0, led_ready}, 32'h1);
		$display("reset test done");
		din <= 1'b1;
		wr(6'h07, 32'h1);
		@(negedge clk);
		check({31'h0, dout}, 32'h1);
		rd(6'h07, 32'h3, 32'h3);
		wr(6'h00, 32'h4);
		@(negedge clk);
		check({31'h0, usi}, 32'h1);
		$display("dio test done");
		ncj = 0;
		repeat (200) @(negedge clk);
		check(ncj, 4);
		n = conv_clk;
		repeat (4) @(negedge clk);
		check({31'h0, conv_clk}, {31'h0, !n[0]});
		rd(6'h0a, {16'h0, cjv}, 32'hffff);
		rd(6'h0b, {16'h0, cjv ^ 16'h00ff}, 32'hffff);
		rd(6'h03, 32'h4, 32'h4);
		$display("sensor test done");
		for (int i = 0; i < 10; i++) g[3*i+:3] = 3'(i % 7);
		wr(6'h10, g);
		rd(6'h10, g, 32'h3fffffff);
		wr(6'h00, 32'h6);
		wait_cond(500, 0);
		$display("config test done");
		rs = xs(rs);
		chs = rs[11:0] | 12'h009;
		wr(6'h01, {20'h0, chs});
		wr(6'h04, 32'h1);
		wr(6'h03, 32'hf);
		burn <= 12'h008;
		wr(6'h02, 32'h1);
		wr(6'h00, 32'h5);
		wait_cond(60000, 1);
		for (int i = 0; i < 12; i++)
			rd(6'h09, {8'h0, base ^ 24'(i * 24'h010203)},
				chs[i] ? 32'hffffff : 32'h0);
		rd(6'h06, 32'h8, 32'h8);
		rd(6'h03, 32'h9, 32'h9);
		wr(6'h03, 32'hf);
		@(negedge clk);
		check({31'h0, irq}, 32'h0);
		$display("acquisition test done");
		end_of_test();
	end
endmodule
